// [src/dac_cmd_port.sv]
// write-only two-wire slave and command decoder for an eight-channel dac
// assumes the link lines are asynchronous to pclk and far slower than it
//
// Functional notes
// - sample data on rising serial clock
// - sda released except acknowledge slots, pull-down only
// - three-state straps select slave address
// - outputs reset to zero, midscale option
// - decode write, update, power-down, no-op
// - write-update-all and write-update-one commands
// - channel field selects A..H or all
// - host sends only defined codes
// - lines held high when idle
// - receive-only slave, reads get nothing
// - start is sda fall with scl high
// - stop is sda rise, bus free
// - ack low through whole ack pulse
// - master clocks ack, releases sda
// - read attempt not acknowledged
// - ack three data bytes, execute as third byte ends
// - command, channel, then 16-bit code msb first
// - extra data bytes not acknowledged
// - update copies input, clears power-down
`timescale 1ns/1ps
`default_nettype none
module dac_cmd_port
  import dac_link_pkg::*;
#(
  parameter int RES_BITS = 16,
  parameter bit MIDSCALE_RESET = 1'b0
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // serial link
  dac_link_if.device link,
  // address straps, three-state each
  input wire logic [1:0] addr_strap_0,
  input wire logic [1:0] addr_strap_1,
  input wire logic [1:0] addr_strap_2,
  // converter side
  output logic [NUM_CHANNELS*CODE_W-1:0] channel_outputs,
  output logic [NUM_CHANNELS-1:0] channel_power_down
);

  if (RES_BITS != 12 && RES_BITS != 14 && RES_BITS != 16)
  begin : g_bad_res
    $error("RES_BITS must be 12, 14 or 16");
  end

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_RECV = 2'b01,
    ST_ACK = 2'b11,
    ST_SKIP = 2'b10
  } port_state_t;

  localparam logic [15:0] CODE_MASK = 16'(16'hFFFF << (16 - RES_BITS));
  localparam logic [15:0] RESET_CODE = MIDSCALE_RESET ? CODE_MID : CODE_ZERO;

  function automatic logic [1:0] strap_level(input logic [1:0] code);
    if (code == STRAP_LOW)
      return 2'h0;
    else if (code == STRAP_OPEN)
      return 2'h1;
    else
      return 2'h2;
  endfunction

  // straps index the 27-entry address table; entries fall in runs of four
  function automatic logic [6:0] strap_addr(input logic [1:0] s2, input logic [1:0] s1,
                                            input logic [1:0] s0);
    logic [4:0] idx;
    idx = 5'(strap_level(s2) * 9 + strap_level(s1) * 3 + strap_level(s0));
    return {3'(idx[4:2] + 3'h1), 2'h0, idx[1:0]};
  endfunction

  function automatic logic chan_hit(input logic [3:0] chan, input int g);
    return (chan == CHAN_ALL) || (chan == 4'(g));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers: link lines and straps are outside pclk

  logic scl_meta, scl_sync, scl_prev;
  logic sda_meta, sda_sync, sda_prev;
  logic [5:0] strap_meta, strap_sync;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      scl_meta <= link.scl;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= link.sda;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  // straps are static; resampling each cycle costs nothing and needs no latch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_meta <= 6'h00;
      strap_sync <= 6'h00;
    end
    else
    begin
      strap_meta <= {addr_strap_2, addr_strap_1, addr_strap_0};
      strap_sync <= strap_meta;
    end
  end

  logic scl_rise, scl_fall, start_seen, stop_seen;
  logic [6:0] own_addr;

  assign scl_rise = scl_sync && !scl_prev;
  assign scl_fall = !scl_sync && scl_prev;
  assign start_seen = scl_sync && scl_prev && sda_prev && !sda_sync;
  assign stop_seen = scl_sync && scl_prev && !sda_prev && sda_sync;
  assign own_addr = strap_addr(strap_sync[5:4], strap_sync[3:2], strap_sync[1:0]);

  ////////////////////////////////////////////////////////////////////////////
  // byte framing

  port_state_t state;
  logic [3:0] bit_cnt;
  logic [2:0] byte_cnt;
  logic [7:0] shift;
  logic byte_done;

  assign byte_done = (state == ST_RECV) && scl_fall && (bit_cnt == 4'h8);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      byte_cnt <= 3'h0;
    end
    else if (start_seen)
    begin
      state <= ST_RECV;
      bit_cnt <= 4'h0;
      byte_cnt <= 3'h0;
    end
    else if (stop_seen)
      state <= ST_IDLE;
    else
    begin
      unique case (state)
        ST_IDLE, ST_SKIP:
          state <= state;
        ST_RECV:
        begin
          if (scl_rise)
            bit_cnt <= 4'(bit_cnt + 4'h1);
          if (byte_done)
            state <= ST_ACK;
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt <= 4'h0;
            if (byte_cnt != 3'h4)
              byte_cnt <= 3'(byte_cnt + 3'h1);
            // foreign or read address: ignore until next start
            state <= (byte_cnt == 3'h0 && !link.dev_sda_oe) ? ST_SKIP : ST_RECV;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      shift <= 8'h00;
    else if (state == ST_RECV && scl_rise)
      shift <= {shift[6:0], sda_sync};
  end

  ////////////////////////////////////////////////////////////////////////////
  // acknowledge drive

  logic addr_ok;
  assign addr_ok = ((shift[7:1] == own_addr) || (shift[7:1] == GLOBAL_ADDR)) && !shift[0];

  assign link.dev_sda_o = 1'b0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      link.dev_sda_oe <= 1'b0;
    else if (start_seen || stop_seen)
      link.dev_sda_oe <= 1'b0;
    // held low from fall to fall
    // no ack past third data byte
    else if (byte_done)
      link.dev_sda_oe <= (byte_cnt == 3'h0) ? addr_ok : (byte_cnt <= 3'(DATA_BYTES));
    else if (state == ST_ACK && scl_fall)
      link.dev_sda_oe <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // command word assembly

  logic [15:0] word_hi;
  logic exec;
  logic [23:0] exec_word;

  // command/channel byte, then code msb first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      word_hi <= 16'h0000;
    else if (start_seen || stop_seen)
      word_hi <= 16'h0000;
    else if (byte_done && byte_cnt != 3'h0)
      word_hi <= {word_hi[7:0], shift};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      exec <= 1'b0;
      exec_word <= 24'h000000;
    end
    else
    begin
      exec <= byte_done && (byte_cnt == 3'(DATA_BYTES));
      if (byte_done && byte_cnt == 3'(DATA_BYTES))
        exec_word <= {word_hi, shift};
    end
  end

  logic [3:0] cmd;
  logic [3:0] chan;
  logic [15:0] code;

  assign cmd = exec_word[23:20];
  assign chan = exec_word[19:16];
  // low bits ignored in narrower builds
  assign code = exec_word[15:0] & CODE_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // channel registers

  for (genvar g = 0; g < NUM_CHANNELS; g++)
  begin : g_chan
    logic [15:0] input_reg;
    logic [15:0] output_reg;
    logic sel;

    assign sel = chan_hit(chan, g);
    assign channel_outputs[g*CODE_W +: CODE_W] = output_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        input_reg <= RESET_CODE;
        output_reg <= RESET_CODE;
        channel_power_down[g] <= 1'b0;
      end
      else if (exec)
      begin
        // reserved codes fall to default and change nothing
        case (cmd)
          CMD_WRITE:
            if (sel)
              input_reg <= code;
          CMD_UPDATE:
            if (sel)
            begin
              output_reg <= input_reg;
              channel_power_down[g] <= 1'b0;
            end
          CMD_WRITE_UPDATE_ALL:
          begin
            if (sel)
              input_reg <= code;
            output_reg <= sel ? code : input_reg;
            channel_power_down[g] <= 1'b0;
          end
          CMD_WRITE_UPDATE:
            if (sel)
            begin
              input_reg <= code;
              output_reg <= code;
              channel_power_down[g] <= 1'b0;
            end
          CMD_POWER_DOWN:
            if (sel)
              channel_power_down[g] <= 1'b1;
          default:
            input_reg <= input_reg;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// [src/dac_link_if.sv]
// two-wire link between the bus master end and the dac command port
// assumes open-drain sda: a driver that is enabled pulls the line low
`timescale 1ns/1ps
`default_nettype none
interface dac_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // wired-and with pull-up
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
  modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface
`default_nettype wire

// [src/dac_link_master.sv]
// bus master end: apb registers order one write frame on the link
// assumes the link runs at pclk / SCL_DIV and the slave never stretches scl
`timescale 1ns/1ps
`default_nettype none
module dac_link_master
  import dac_link_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link
  dac_link_if.host link
);

  if (SCL_DIV != 8)
  begin : g_bad_div
    $error("phase plan needs SCL_DIV of 8");
  end

  typedef enum logic [2:0]
  {
    H_IDLE = 3'b000,
    H_START = 3'b001,
    H_BIT = 3'b011,
    H_ACK = 3'b010,
    H_STOP = 3'b110
  } host_state_t;

  host_state_t state;
  logic [2:0] phase;
  logic [2:0] bit_idx;
  logic [2:0] byte_idx;
  logic [2:0] byte_count;
  logic read_bit;
  logic [6:0] slave_addr;
  logic [23:0] word;
  logic addr_nack;
  logic [2:0] ack_count;
  logic last_ack;
  logic sda_low;
  logic sda_meta, sda_sync;
  logic wr_en, go;
  logic [7:0] cur_byte;

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en = psel && penable && pwrite;
  // a go while busy is dropped
  assign go = wr_en && paddr == REG_CTRL && pwdata[CTRL_GO] && state == H_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      read_bit <= 1'b0;
      byte_count <= CTRL_COUNT_RESET;
      slave_addr <= 7'h00;
      word <= 24'h000000;
    end
    else if (wr_en && state == H_IDLE)
    begin
      if (paddr == REG_CTRL)
      begin
        read_bit <= pwdata[CTRL_READ];
        byte_count <= pwdata[CTRL_COUNT_LSB +: 3];
      end
      if (paddr == REG_ADDR)
        slave_addr <= pwdata[6:0];
      if (paddr == REG_WORD)
        word <= pwdata[23:0];
    end
  end

  always_comb
  begin
    prdata = 32'h00000000;
    unique case (paddr)
      REG_CTRL:
        prdata = {25'h0, byte_count, 2'h0, read_bit, 1'b0};
      REG_ADDR:
        prdata = {25'h0, slave_addr};
      REG_WORD:
        prdata = {8'h00, word};
      REG_STATUS:
        prdata = {25'h0, ack_count, 2'h0, addr_nack, state != H_IDLE};
      default:
        prdata = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame sequencer

  always_comb
  begin
    unique case (byte_idx)
      3'h0: cur_byte = {slave_addr, read_bit};
      3'h1: cur_byte = word[23:16];
      3'h2: cur_byte = word[15:8];
      3'h3: cur_byte = word[7:0];
      default: cur_byte = EXTRA_BYTE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
    end
    else
    begin
      sda_meta <= link.sda;
      sda_sync <= sda_meta;
    end
  end

  assign link.scl = (state == H_IDLE || state == H_START) ? 1'b1 : phase[2];
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = sda_low;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= H_IDLE;
      phase <= 3'h0;
      bit_idx <= 3'h0;
      byte_idx <= 3'h0;
      sda_low <= 1'b0;
      last_ack <= 1'b0;
      addr_nack <= 1'b0;
      ack_count <= 3'h0;
    end
    else if (state == H_IDLE)
    begin
      phase <= 3'h0;
      if (go)
      begin
        state <= H_START;
        bit_idx <= 3'h0;
        byte_idx <= 3'h0;
        addr_nack <= 1'b0;
        ack_count <= 3'h0;
      end
    end
    else
    begin
      phase <= 3'(phase + 3'h1);
      unique case (state)
        H_START:
        begin
          if (phase == 3'h2)
            sda_low <= 1'b1;
          if (phase == 3'h7)
            state <= H_BIT;
        end
        // msb first, changed while scl low
        H_BIT:
        begin
          if (phase == 3'h1)
            sda_low <= !cur_byte[3'h7 - bit_idx];
          if (phase == 3'h7)
          begin
            bit_idx <= 3'(bit_idx + 3'h1);
            if (bit_idx == 3'h7)
              state <= H_ACK;
          end
        end
        H_ACK:
        begin
          if (phase == 3'h1)
            sda_low <= 1'b0;
          if (phase == 3'h6)
          begin
            last_ack <= !sda_sync;
            if (!sda_sync)
              ack_count <= 3'(ack_count + 3'h1);
          end
          if (phase == 3'h7)
          begin
            if (!last_ack || byte_idx == byte_count)
            begin
              addr_nack <= !last_ack && byte_idx == 3'h0;
              state <= H_STOP;
            end
            else
            begin
              byte_idx <= 3'(byte_idx + 3'h1);
              state <= H_BIT;
            end
          end
        end
        H_STOP:
        begin
          if (phase == 3'h1)
            sda_low <= 1'b1;
          if (phase == 3'h6)
            sda_low <= 1'b0;
          if (phase == 3'h7)
            state <= H_IDLE;
        end
        default:
          state <= H_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// [src/dac_link_pkg.sv]
// constants shared by the two ends of the dac command link
// assumes a 10 MHz pclk on both ends and a bench link period of 800 ns
package dac_link_pkg;

  // clock and link timing
  localparam int PCLK_PERIOD_NS = 100;
  localparam int SCL_PERIOD_NS = 800;
  localparam int SCL_DIV = SCL_PERIOD_NS / PCLK_PERIOD_NS;

  // command field codes
  localparam logic [3:0] CMD_WRITE = 4'h0;
  localparam logic [3:0] CMD_UPDATE = 4'h1;
  localparam logic [3:0] CMD_WRITE_UPDATE_ALL = 4'h2;
  localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
  localparam logic [3:0] CMD_POWER_DOWN = 4'h4;
  localparam logic [3:0] CMD_NOP = 4'hF;

  // channel field
  localparam logic [3:0] CHAN_ALL = 4'hF;
  localparam int NUM_CHANNELS = 8;
  localparam int CODE_W = 16;
  localparam int DATA_BYTES = 3;

  // addressing
  localparam logic [6:0] GLOBAL_ADDR = 7'h73;
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_OPEN = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;

  // power-on codes
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MID = 16'h8000;

  // host register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WORD = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int CTRL_GO = 0;
  localparam int CTRL_READ = 1;
  localparam int CTRL_COUNT_LSB = 4;
  localparam logic [2:0] CTRL_COUNT_RESET = 3'h3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ADDR_NACK = 1;
  localparam int STAT_ACKS_LSB = 4;
  localparam logic [7:0] EXTRA_BYTE = 8'h00;

endpackage

// [test/dac_link_assertions.sv]
// checker for the two-wire link between the master end and the dac command port
// assumes both ends run on pclk and the master makes scl from pclk
`timescale 1ns/1ps
`default_nettype none
module dac_link_assertions
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link lines
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////////
  a_idle_release: assert property ($rose(presetn) |-> scl && sda)
    else $error("link not idle after reset");
  a_dev_pulls_low: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("device drives sda high");
  // taking the line with scl high would fake a start
  a_ack_take_low: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("device took sda while scl high");
  a_ack_drop_low: assert property ($fell(dev_sda_oe) |-> !scl)
    else $error("device released sda while scl high");
  a_ack_full_high: assert property (dev_sda_oe && $rose(scl) |-> dev_sda_oe[*4])
    else $error("ack not held over scl high");
  a_ack_bounded: assert property ($rose(dev_sda_oe) |-> ##[4:12] !dev_sda_oe)
    else $error("ack held too long");
  a_host_off_ack: assert property (dev_sda_oe && scl |-> !host_sda_oe)
    else $error("master drives sda in ack pulse");
  a_start_quiet: assert property (scl && $past(scl) && $fell(sda) |-> !dev_sda_oe[*8])
    else $error("device drives sda at start");
  a_stop_free: assert property (scl && $rose(sda) |-> !dev_sda_oe[*4])
    else $error("device drives sda after stop");
  a_scl_high_len: assert property ($rose(scl) |-> scl[*4])
    else $error("scl high phase short");
  a_scl_low_len: assert property ($fell(scl) |-> !scl[*4] ##1 scl)
    else $error("scl low phase wrong");
endmodule
`default_nettype wire

// [test/testbench.sv]
// self-checking bench: apb master end drives frames into the dac command port
// assumes both ends share pclk; straps are driven by the bench
`timescale 1ns/1ps
`default_nettype none
`define CHECK(what, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("ERROR %s expected %h seen %h", what, exp, got); \
    end \
  end
module testbench
  import dac_link_pkg::*;
;
  // low bits masked: a 12-bit build shows the don't-care handling
  localparam int RES = 12;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] addr_strap_0, addr_strap_1, addr_strap_2;
  logic [NUM_CHANNELS*CODE_W-1:0] chan_out, exp_in, exp_out;
  logic [NUM_CHANNELS-1:0] pd, exp_pd;
  logic [35:0] cap;
  int errors, cmp_count, ack_cnt, nbit;

  ////////////////////////////////////////////////////////////////////////////////
  dac_link_if dac_link_if_i ();
  dac_link_master dac_link_master_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(dac_link_if_i));
  dac_cmd_port #(.RES_BITS(RES), .MIDSCALE_RESET(1'b1)) dac_cmd_port_i (.pclk(pclk),
    .presetn(presetn), .link(dac_link_if_i), .addr_strap_0(addr_strap_0),
    .addr_strap_1(addr_strap_1), .addr_strap_2(addr_strap_2),
    .channel_outputs(chan_out), .channel_power_down(pd));
  dac_link_assertions dac_link_assertions_i (.pclk(pclk), .presetn(presetn),
    .scl(dac_link_if_i.scl), .sda(dac_link_if_i.sda),
    .host_sda_oe(dac_link_if_i.host_sda_oe), .dev_sda_o(dac_link_if_i.dev_sda_o),
    .dev_sda_oe(dac_link_if_i.dev_sda_oe));

  always #50 pclk = ~pclk;

  // wire monitor: bits as the device samples them, acks seen on the line
  always @(posedge dac_link_if_i.scl)
  begin
    if (dac_link_if_i.dev_sda_oe === 1'b1)
      ack_cnt++;
    if (nbit < 36)
    begin
      cap = {cap[34:0], dac_link_if_i.sda};
      nbit++;
    end
  end
  always @(negedge dac_link_if_i.sda)
    if (dac_link_if_i.scl === 1'b1)
      nbit = 0;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      errors++;
      complete_run();
    end
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [6:0] addr_of(input int i);
    return {3'(i / 4 + 1), 2'b00, 2'(i % 4)};
  endfunction

  task automatic model(input logic [3:0] cmd, input logic [3:0] ch, input logic [15:0] code);
    logic [7:0] sel;
    logic [15:0] c;
    sel = (ch == CHAN_ALL) ? 8'hFF : (ch < 4'h8) ? 8'h01 << ch : 8'h00;
    c = code & (16'hFFFF << (CODE_W - RES));
    for (int g = 0; g < NUM_CHANNELS; g++)
    begin
      if (sel[g] && cmd inside {CMD_WRITE, CMD_WRITE_UPDATE_ALL, CMD_WRITE_UPDATE})
        exp_in[g*16 +: 16] = c;
      if ((sel[g] && cmd inside {CMD_UPDATE, CMD_WRITE_UPDATE}) || cmd == CMD_WRITE_UPDATE_ALL)
      begin
        exp_out[g*16 +: 16] = exp_in[g*16 +: 16];
        exp_pd[g] = 1'b0;
      end
      if (sel[g] && cmd == CMD_POWER_DOWN)
        exp_pd[g] = 1'b1;
    end
  endtask

  // one frame ordered over apb; acks = 0 none, 3 partial, 4 full command
  task automatic run(input logic [6:0] a, input logic rd, input logic [2:0] cnt,
                     input logic [3:0] cmd, input logic [3:0] ch, input logic [15:0] code,
                     input int acks);
    logic [31:0] r;
    logic [23:0] w;
    int n;
    w = {cmd, ch, code};
    ack_cnt = 0;
    apb(1'b1, REG_ADDR, {25'h0, a}, r);
    apb(1'b1, REG_WORD, {8'h00, w}, r);
    apb(1'b0, REG_WORD, 32'h0, r);
    `CHECK("word readback", {8'h00, w}, r)
    `CHECK("pslverr", 1'b0, pslverr)
    apb(1'b1, REG_CTRL, {25'h0, cnt, 2'b00, rd, 1'b1}, r);
    n = 0;
    do
    begin
      apb(1'b0, REG_STATUS, 32'h0, r);
      n++;
    end
    while (r[STAT_BUSY] !== 1'b0 && n < 200);
    if (r[STAT_BUSY] !== 1'b0)
    begin
      errors++;
      complete_run();
    end
    if (acks == 4)
      model(cmd, ch, code);
    `CHECK("acks", acks, ack_cnt)
    `CHECK("status acks", acks, r[STAT_ACKS_LSB +: 3])
    `CHECK("addr nack", 1'(acks == 0), r[STAT_ADDR_NACK])
    if (acks == 4 && cnt == 3'h3)
      `CHECK("wire bits", {a, rd, 1'b0, w[23:16], 1'b0, w[15:8], 1'b0, w[7:0], 1'b0}, cap)
    `CHECK("outputs", exp_out, chan_out)
    `CHECK("power down", exp_pd, pd)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {addr_strap_2, addr_strap_1, addr_strap_0} = {STRAP_LOW, STRAP_LOW, STRAP_LOW};
    errors = 0;
    cmp_count = 0;
    nbit = 36;
    exp_in = {NUM_CHANNELS{CODE_MID}};
    exp_out = {NUM_CHANNELS{CODE_MID}};
    exp_pd = 8'h00;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHECK("reset outputs", {NUM_CHANNELS{CODE_MID}}, chan_out)
    `CHECK("idle lines", 2'b11, {dac_link_if_i.scl, dac_link_if_i.sda})
    run(addr_of(0), 1'b0, 3'h3, CMD_WRITE, 4'h2, 16'h1234, 4);
    run(addr_of(0), 1'b0, 3'h3, CMD_UPDATE, 4'h2, 16'h0000, 4);
    run(addr_of(0), 1'b0, 3'h3, CMD_POWER_DOWN, CHAN_ALL, 16'hFFFF, 4);
    run(addr_of(0), 1'b0, 3'h3, CMD_WRITE_UPDATE, 4'h5, 16'hABCD, 4);
    run(addr_of(0), 1'b0, 3'h3, CMD_WRITE_UPDATE_ALL, 4'h0, 16'h5A5F, 4);
    run(addr_of(0), 1'b0, 3'h3, CMD_NOP, 4'h1, 16'hFFFF, 4);
    run(GLOBAL_ADDR, 1'b0, 3'h3, CMD_WRITE_UPDATE, 4'h7, 16'h0F0F, 4);
    run(addr_of(1), 1'b0, 3'h3, CMD_WRITE_UPDATE, 4'h3, 16'h1111, 0);
    run(addr_of(0), 1'b1, 3'h3, CMD_WRITE_UPDATE, 4'h3, 16'h2222, 0);
    run(addr_of(0), 1'b0, 3'h2, CMD_WRITE_UPDATE, 4'h3, 16'h3333, 3);
    run(addr_of(0), 1'b0, 3'h5, CMD_WRITE_UPDATE, 4'h4, 16'h4444, 4);
    // straps only settle through synchronisers, so idle a few cycles
    for (int k = 0; k < 3; k++)
    begin
      addr_strap_0 <= 2'(k * 13 % 3);
      addr_strap_1 <= 2'(k * 13 / 3 % 3);
      addr_strap_2 <= 2'(k * 13 / 9);
      repeat (6) @(posedge pclk);
      run(addr_of(k * 13), 1'b0, 3'h3, CMD_WRITE_UPDATE, 4'(k + 1), 16'(k * 16'h1357), 4);
    end
    complete_run();
  end
endmodule
`undef CHECK
`default_nettype wire
